// ---- hdl/dod_pkg.sv ----
package dod_pkg;
    // working register numbers
    localparam logic [3:0] DEFAULT_WORK_REG_W0  = 4'h0;    // implied default register
    localparam logic [3:0] DEFAULT_WORK_REG_W4  = 4'h4;    // lowest multiply register
    localparam logic [3:0] DEFAULT_WORK_REG_W8  = 4'h8;    // x prefetch pointer a
    localparam logic [3:0] DEFAULT_WORK_REG_W9  = 4'h9;    // x prefetch pointer b
    localparam logic [3:0] DEFAULT_WORK_REG_W10 = 4'hA;    // y prefetch pointer a
    localparam logic [3:0] DEFAULT_WORK_REG_W11 = 4'hB;    // y prefetch pointer b
    localparam logic [3:0] DEFAULT_WORK_REG_W12 = 4'hC;    // prefetch index register

    // source addressing modes, 3-bit selector
    localparam logic [2:0] MODE_DIRECT   = 3'h0; // ws
    localparam logic [2:0] MODE_IND      = 3'h1; // [ws]
    localparam logic [2:0] MODE_POSTINC  = 3'h2; // [ws++]
    localparam logic [2:0] MODE_POSTDEC  = 3'h3; // [ws--]
    localparam logic [2:0] MODE_PREINC   = 3'h4; // [++ws]
    localparam logic [2:0] MODE_PREDEC   = 3'h5; // [--ws]
    localparam logic [2:0] MODE_BASEIDX  = 3'h6; // [ws+wb], extended form only

    // prefetch selector, 4 bits: bit3 picks pointer b, low bits the modifier
    localparam logic [2:0] PF_NOMOD   = 3'h0;  // plain indirect
    localparam logic [2:0] PF_PLUS2   = 3'h1;  // post +2
    localparam logic [2:0] PF_PLUS4   = 3'h2;  // post +4
    localparam logic [2:0] PF_PLUS6   = 3'h3;  // post +6
    localparam logic [2:0] PF_INDEXED = 3'h4;  // pointer b + w12 (b only)
    localparam logic [2:0] PF_MINUS6  = 3'h5;  // post -6
    localparam logic [2:0] PF_MINUS4  = 3'h6;  // post -4
    localparam logic [2:0] PF_MINUS2  = 3'h7;  // post -2
    localparam logic [3:0] PF_NONE    = 4'h4;  // pointer a with indexed code
endpackage

// ---- hdl/dod_operand_decoder.sv ----
// Summary of operation
// - square pair is same register w4..w7
// - multiply pairs are six distinct w4..w7 pairs
// - general register selects any of sixteen
// - plain source and destination reach all sixteen
// - implied register is always w0
// - source operand has six addressing modes
// - extended source adds base-indexed seventh mode
// - x prefetch from w8/w9, w9+w12, none
// - y prefetch from w10/w11, w11+w12, none
// - x prefetch destination within w4..w7
// - y prefetch destination within w4..w7
`timescale 1ns/1ps
`default_nettype none
module dod_operand_decoder (
    input  wire logic        clk,            // core clock, 40 MHz
    input  wire logic        srst,           // synchronous reset, active high
    input  wire logic        dec_valid,      // operand fields valid this cycle
    input  wire logic        sq_sel,         // 1: square form, 0: multiply form
    input  wire logic [1:0]  sq_code,        // square pair code
    input  wire logic [2:0]  mul_code,       // multiply pair code, 0..5 legal
    input  wire logic [3:0]  gen_code,       // general register number
    input  wire logic [3:0]  dst_code,       // plain destination number
    input  wire logic [3:0]  src_code,       // plain/source register number
    input  wire logic [2:0]  mode_code,      // source addressing mode
    input  wire logic        ext_form,       // extended source form allowed
    input  wire logic [3:0]  base_code,      // base register for indexed mode
    input  wire logic [3:0]  xpf_code,       // x prefetch selector
    input  wire logic [1:0]  xdst_code,      // x prefetch destination code
    input  wire logic [3:0]  ypf_code,       // y prefetch selector
    input  wire logic [1:0]  ydst_code,      // y prefetch destination code
    output logic             out_valid,      // decoded fields valid
    output logic [3:0]       mul_a_reg,      // multiplicand register
    output logic [3:0]       mul_b_reg,      // multiplier register
    output logic [3:0]       general_work_reg, // decoded general register
    output logic [3:0]       dst_reg,        // decoded destination register
    output logic [3:0]       src_reg,        // decoded source register
    output logic [3:0]       default_work_reg, // implied register
    output logic [2:0]       src_operand_mode, // decoded addressing mode
    output logic [3:0]       base_work_reg,  // base register when indexed
    output logic             xpf_en,         // x prefetch happens
    output logic [3:0]       xpf_ptr,        // x pointer register
    output logic             xpf_indexed,    // x address is ptr + w12
    output logic signed [3:0] xpf_step,      // x post-modify step
    output logic [3:0]       xpf_dst,        // x prefetch destination
    output logic             ypf_en,         // y prefetch happens
    output logic [3:0]       ypf_ptr,        // y pointer register
    output logic             ypf_indexed,    // y address is ptr + w12
    output logic signed [3:0] ypf_step,      // y post-modify step
    output logic [3:0]       ypf_dst,        // y prefetch destination
    output logic             illegal_operand // an encoded selector is illegal
);
    // decoded prefetch: {en, ptr, indexed, step}; every selector code is legal
    typedef struct packed {
        logic              en;
        logic [3:0]        ptr;
        logic              indexed;
        logic signed [3:0] step;
    } dod_pf_s;

    // one decoder serves both spaces; only the pointer pair differs
    function automatic dod_pf_s dod_pf_decode(input logic [3:0] code,
                                              input logic [3:0] ptr_a,
                                              input logic [3:0] ptr_b);
        dod_pf_s r;
        r = '0;
        r.en    = 1'b1;
        r.ptr   = code[3] ? ptr_b : ptr_a;
        // low bits pick the post-modify step
        unique case (code[2:0])
            dod_pkg::PF_NOMOD:   r.step = 4'sh0;
            dod_pkg::PF_PLUS2:   r.step = 4'sh2;
            dod_pkg::PF_PLUS4:   r.step = 4'sh4;
            dod_pkg::PF_PLUS6:   r.step = 4'sh6;
            dod_pkg::PF_MINUS6:  r.step = -4'sh6;
            dod_pkg::PF_MINUS4:  r.step = -4'sh4;
            dod_pkg::PF_MINUS2:  r.step = -4'sh2;
            dod_pkg::PF_INDEXED:
            begin
                // indexed exists only on pointer b; the a-slot means none
                r.indexed = code[3];
                r.en      = code[3];
                r.ptr     = code[3] ? ptr_b : 4'h0;
            end
        endcase
        return r;
    endfunction

    // combinational decode of the current fields
    logic [3:0]  mula_next;      // multiplicand
    logic [3:0]  mulb_next;      // multiplier
    logic        mul_bad;        // multiply pair code out of range
    logic        mode_bad;       // mode not allowed for this form
    logic [3:0]  base_next;      // base register if indexed mode
    dod_pf_s     xpf_d;          // x prefetch decode
    dod_pf_s     ypf_d;          // y prefetch decode

    // multiplier pair selection
    always_comb
    begin
        mula_next = dod_pkg::DEFAULT_WORK_REG_W4;
        mulb_next = dod_pkg::DEFAULT_WORK_REG_W4;
        mul_bad   = 1'b0;
        if (sq_sel)
        begin
            // same register twice, w4..w7 by construction
            mula_next = dod_pkg::DEFAULT_WORK_REG_W4 + {2'h0, sq_code};
            mulb_next = dod_pkg::DEFAULT_WORK_REG_W4 + {2'h0, sq_code};
        end
        else
        begin
            // pair codes ascend, a is always the lower register
            unique case (mul_code)
                3'h0:
                begin
                    mula_next = 4'h4;
                    mulb_next = 4'h5;
                end
                3'h1:
                begin
                    mula_next = 4'h4;
                    mulb_next = 4'h6;
                end
                3'h2:
                begin
                    mula_next = 4'h4;
                    mulb_next = 4'h7;
                end
                3'h3:
                begin
                    mula_next = 4'h5;
                    mulb_next = 4'h6;
                end
                3'h4:
                begin
                    mula_next = 4'h5;
                    mulb_next = 4'h7;
                end
                3'h5:
                begin
                    mula_next = 4'h6;
                    mulb_next = 4'h7;
                end
                default: mul_bad = 1'b1;  // codes 6,7 flagged, not remapped
            endcase
        end
    end

    // addressing mode legality
    always_comb
    begin
        base_next = 4'h0;
        mode_bad  = 1'b0;
        if (mode_code == dod_pkg::MODE_BASEIDX)
        begin
            // seventh mode only on the extended form
            mode_bad  = !ext_form;
            base_next = base_code;
        end
        else if (mode_code > dod_pkg::MODE_BASEIDX)
        begin
            // mode 7 has no meaning in either form
            mode_bad = 1'b1;
        end
    end

    // prefetch address decode for both data spaces
    always_comb
    begin
        xpf_d = dod_pf_decode(xpf_code, dod_pkg::DEFAULT_WORK_REG_W8, dod_pkg::DEFAULT_WORK_REG_W9);
        ypf_d = dod_pf_decode(ypf_code, dod_pkg::DEFAULT_WORK_REG_W10, dod_pkg::DEFAULT_WORK_REG_W11);
    end

    // registered multiply and register outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mul_a_reg        <= dod_pkg::DEFAULT_WORK_REG_W4;
            mul_b_reg        <= dod_pkg::DEFAULT_WORK_REG_W4;
            general_work_reg <= 4'h0;
            dst_reg          <= 4'h0;
            src_reg          <= 4'h0;
            default_work_reg <= dod_pkg::DEFAULT_WORK_REG_W0;
        end
        else if (dec_valid)
        begin
            mul_a_reg        <= mula_next;
            mul_b_reg        <= mulb_next;
            general_work_reg <= gen_code;
            dst_reg          <= dst_code;
            src_reg          <= src_code;
            default_work_reg <= dod_pkg::DEFAULT_WORK_REG_W0;
        end
    end

    // registered mode outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            src_operand_mode <= dod_pkg::MODE_DIRECT;
            base_work_reg    <= 4'h0;
        end
        else if (dec_valid)
        begin
            src_operand_mode <= mode_code;
            base_work_reg    <= base_next;
        end
    end

    // registered prefetch outputs; destinations are w4 plus a 2-bit code
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            xpf_en      <= 1'b0;
            xpf_ptr     <= 4'h0;
            xpf_indexed <= 1'b0;
            xpf_step    <= 4'sh0;
            xpf_dst     <= dod_pkg::DEFAULT_WORK_REG_W4;
            ypf_en      <= 1'b0;
            ypf_ptr     <= 4'h0;
            ypf_indexed <= 1'b0;
            ypf_step    <= 4'sh0;
            ypf_dst     <= dod_pkg::DEFAULT_WORK_REG_W4;
        end
        else if (dec_valid)
        begin
            xpf_en      <= xpf_d.en;
            xpf_ptr     <= xpf_d.ptr;
            xpf_indexed <= xpf_d.indexed;
            xpf_step    <= xpf_d.step;
            xpf_dst     <= dod_pkg::DEFAULT_WORK_REG_W4 + {2'h0, xdst_code};
            ypf_en      <= ypf_d.en;
            ypf_ptr     <= ypf_d.ptr;
            ypf_indexed <= ypf_d.indexed;
            ypf_step    <= ypf_d.step;
            ypf_dst     <= dod_pkg::DEFAULT_WORK_REG_W4 + {2'h0, ydst_code};
        end
    end

    // valid and illegal flags follow each decode by one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            out_valid       <= 1'b0;
            illegal_operand <= 1'b0;
        end
        else
        begin
            out_valid       <= dec_valid;
            illegal_operand <= dec_valid && ((!sq_sel && mul_bad) || mode_bad);
        end
    end

    // checks
    AST_SQ_SAME: assert property (@(posedge clk) disable iff (srst)
        dec_valid && sq_sel |=> mul_a_reg == mul_b_reg && mul_a_reg[3:2] == 2'h1)
        else $error("square pair not a repeated w4..w7");
    AST_MUL_PAIR: assert property (@(posedge clk) disable iff (srst)
        dec_valid && !sq_sel && mul_code < 3'h6 |=>
        mul_a_reg < mul_b_reg && mul_a_reg[3:2] == 2'h1 && mul_b_reg[3:2] == 2'h1)
        else $error("multiply pair not distinct w4..w7");
    AST_GEN_REG: assert property (@(posedge clk) disable iff (srst)
        dec_valid |=> general_work_reg == $past(gen_code))
        else $error("general register mismatch");
    AST_SRC_DST: assert property (@(posedge clk) disable iff (srst)
        dec_valid |=> dst_reg == $past(dst_code) && src_reg == $past(src_code))
        else $error("plain register mismatch");
    AST_DEFAULT_W0: assert property (@(posedge clk) disable iff (srst)
        out_valid |-> default_work_reg == dod_pkg::DEFAULT_WORK_REG_W0)
        else $error("implied register not w0");
    AST_MODE: assert property (@(posedge clk) disable iff (srst)
        dec_valid && mode_code < dod_pkg::MODE_BASEIDX |=> src_operand_mode == $past(mode_code)
        && !illegal_operand || (!$past(sq_sel) && $past(mul_code) > 3'h5))
        else $error("plain mode mishandled");
    AST_BASEIDX: assert property (@(posedge clk) disable iff (srst)
        dec_valid && mode_code == dod_pkg::MODE_BASEIDX && !ext_form |=> illegal_operand)
        else $error("indexed mode accepted on plain form");
    AST_XPF: assert property (@(posedge clk) disable iff (srst)
        dec_valid && xpf_code == 4'hC |=> xpf_en && xpf_indexed && xpf_ptr == 4'h9)
        else $error("x indexed prefetch wrong");
    AST_XPF_NONE: assert property (@(posedge clk) disable iff (srst)
        dec_valid && xpf_code == dod_pkg::PF_NONE |=> !xpf_en)
        else $error("x none prefetch enabled");
    AST_YPF: assert property (@(posedge clk) disable iff (srst)
        dec_valid && ypf_code == 4'h3 |=> ypf_en && ypf_ptr == 4'hA && ypf_step == 4'sh6)
        else $error("y post +6 prefetch wrong");
    AST_XDST: assert property (@(posedge clk) disable iff (srst)
        out_valid |-> xpf_dst[3:2] == 2'h1)
        else $error("x destination outside w4..w7");
    AST_YDST: assert property (@(posedge clk) disable iff (srst)
        out_valid |-> ypf_dst[3:2] == 2'h1)
        else $error("y destination outside w4..w7");
    AST_ILLEGAL: assert property (@(posedge clk) disable iff (srst)
        dec_valid && !sq_sel && mul_code > 3'h5 |=> illegal_operand && out_valid)
        else $error("bad multiply code not flagged");
endmodule
`default_nettype wire

// ---- dv/dod_tb_types.svh ----
`ifndef DOD_TB_TYPES_SVH
`define DOD_TB_TYPES_SVH
// one decode request as the fetch stage presents it
typedef struct packed {
    logic       sq_sel;     // square form
    logic [1:0] sq_code;    // square pair
    logic [2:0] mul_code;   // multiply pair
    logic [3:0] gen_code;   // general register
    logic [3:0] dst_code;   // destination register
    logic [3:0] src_code;   // source register
    logic [2:0] mode_code;  // addressing mode
    logic       ext_form;   // extended source form
    logic [3:0] base_code;  // base register
    logic [3:0] xpf_code;   // x prefetch selector
    logic [1:0] xdst_code;  // x destination
    logic [3:0] ypf_code;   // y prefetch selector
    logic [1:0] ydst_code;  // y destination
} dod_req_s;
`endif

// ---- dv/dod_fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dod_tb_types.svh"
// fetch stage stand-in: presents one request per asked cycle
module dod_fetch_model (
    input  wire logic     clk,       // core clock
    input  wire logic     issue,     // present a request next
    input  wire dod_req_s req,       // request fields
    output var  logic     dec_valid, // fields valid
    output var  dod_req_s fld        // fields toward decoder
);
    // known values from time zero
    initial
    begin
        dec_valid = 1'b0;
        fld = '0;
    end

    // drive on the falling edge; idle fields are inverted every cycle
    // so the decoder cannot lean on stale values between requests
    always @(negedge clk)
    begin
        dec_valid <= issue;
        if (issue)
            fld <= req;
        else
            fld <= ~fld;
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dod_tb_types.svh"
module testbench;
    logic       clk = 1'b0;   // core clock
    logic       srst = 1'b1;  // held at start
    logic       issue = 1'b0; // ask model for a request
    dod_req_s   req = '0;     // next request
    dod_req_s   fld;          // fields as presented
    logic       dec_valid;    // presented valid
    logic       out_valid, xpf_en, xpf_indexed, ypf_en, ypf_indexed, illegal_operand;
    logic [3:0] mul_a_reg, mul_b_reg, general_work_reg, dst_reg, src_reg, default_work_reg;
    logic [3:0] base_work_reg, xpf_ptr, xpf_dst, ypf_ptr, ypf_dst;
    logic [3:0] xpf_step, ypf_step; // raw bits of signed steps
    logic [2:0] src_operand_mode;   // decoded mode
    int         error_cnt = 0;
    int         samples_checked = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    dod_fetch_model u_dod_fetch_model (.clk, .issue, .req, .dec_valid, .fld);
    dod_operand_decoder u_dod_operand_decoder (.clk, .srst, .dec_valid,
        .sq_sel(fld.sq_sel), .sq_code(fld.sq_code), .mul_code(fld.mul_code),
        .gen_code(fld.gen_code), .dst_code(fld.dst_code), .src_code(fld.src_code),
        .mode_code(fld.mode_code), .ext_form(fld.ext_form), .base_code(fld.base_code),
        .xpf_code(fld.xpf_code), .xdst_code(fld.xdst_code), .ypf_code(fld.ypf_code),
        .ydst_code(fld.ydst_code), .out_valid, .mul_a_reg, .mul_b_reg, .general_work_reg,
        .dst_reg, .src_reg, .default_work_reg, .src_operand_mode, .base_work_reg, .xpf_en,
        .xpf_ptr, .xpf_indexed, .xpf_step, .xpf_dst, .ypf_en, .ypf_ptr, .ypf_indexed,
        .ypf_step, .ypf_dst, .illegal_operand);

    // single compare point
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // legal request: square form, direct mode, no prefetch
    function automatic dod_req_s idle_req();
        dod_req_s r;
        r = '0;
        r.sq_sel = 1'b1;
        r.xpf_code = dod_pkg::PF_NONE;
        r.ypf_code = dod_pkg::PF_NONE;
        return r;
    endfunction

    // one request, then look at the answer on the falling edge after it is captured
    task automatic dec(input dod_req_s r);
        @(posedge clk);
        req = r;
        issue = 1'b1;
        @(posedge clk);
        issue = 1'b0;
        @(negedge clk);
        chk(8'(out_valid), 8'h01);
    endtask

    // values right after any reset
    task automatic chk_rst();
        chk(8'(out_valid | illegal_operand | xpf_en | ypf_en), 8'h00);
        chk({mul_a_reg, mul_b_reg}, 8'h44);
        chk(8'(default_work_reg), 8'h00);
        chk({xpf_dst, ypf_dst}, 8'h44);
    endtask

    // prefetch answer against selector; pointer b sits one above a
    task automatic pf_chk(input logic [3:0] c, input logic [1:0] d, input logic [3:0] pa,
        input logic en, input logic [3:0] ptr, input logic idx, input logic [3:0] st,
        input logic [3:0] dst);
        logic [3:0] steps [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'hA, 4'hC, 4'hE};
        logic none;
        none = (c == dod_pkg::PF_NONE);
        chk(8'(en), 8'(!none));
        chk(8'(ptr), none ? 8'h00 : 8'(pa + 4'(c[3])));
        if (!none)
            chk(8'(idx), 8'(c[2:0] == dod_pkg::PF_INDEXED));
        if (c[2:0] != dod_pkg::PF_INDEXED)
            chk(8'(st), 8'(steps[c[2:0]]));
        chk(8'(dst), 8'(dod_pkg::DEFAULT_WORK_REG_W4 + 4'(d)));
    endtask

    task automatic t_square();
        dod_req_s r;
        for (int i = 0; i < 4; i++)
        begin
            r = idle_req();
            r.sq_code = i[1:0];
            dec(r);
            chk({mul_a_reg, mul_b_reg}, {2{dod_pkg::DEFAULT_WORK_REG_W4 + 4'(i)}});
            chk(8'(illegal_operand), 8'h00);
        end
        $display("test square done");
    endtask

    // six legal pairs, then both unused codes
    task automatic t_mul();
        logic [7:0] pairs [8] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67, 8'h44, 8'h44};
        dod_req_s r;
        for (int i = 0; i < 8; i++)
        begin
            r = idle_req();
            r.sq_sel = 1'b0;
            r.mul_code = i[2:0];
            dec(r);
            chk({mul_a_reg, mul_b_reg}, pairs[i]);
            chk(8'(illegal_operand), 8'(i > 5));
        end
        $display("test multiply done");
    endtask

    task automatic t_regs();
        dod_req_s r;
        for (int i = 0; i < 16; i++)
        begin
            r = idle_req();
            r.gen_code = i[3:0];
            r.dst_code = 4'hF - i[3:0];
            r.src_code = i[3:0] ^ 4'h5;
            dec(r);
            chk(8'(general_work_reg), 8'(i));
            chk({dst_reg, src_reg}, {4'hF - i[3:0], i[3:0] ^ 4'h5});
            chk(8'(default_work_reg), 8'h00);
        end
        $display("test registers done");
    endtask

    // every mode with and without the extended form
    task automatic t_modes();
        dod_req_s r;
        for (int i = 0; i < 16; i++)
        begin
            r = idle_req();
            r.mode_code = i[2:0];
            r.ext_form = i[3];
            r.base_code = 4'h8 + i[3:0];
            dec(r);
            chk(8'(src_operand_mode), 8'(i[2:0]));
            chk(8'(base_work_reg), (i[2:0] == 3'h6) ? 8'(r.base_code) : 8'h00);
            chk(8'(illegal_operand), 8'(i[2:0] == 3'h7 || i[3:0] == 4'h6));
        end
        $display("test modes done");
    endtask

    task automatic t_prefetch();
        dod_req_s r;
        for (int i = 0; i < 16; i++)
        begin
            r = idle_req();
            r.xpf_code = i[3:0];
            r.ypf_code = 4'hF - i[3:0];
            r.xdst_code = i[1:0];
            r.ydst_code = ~i[1:0];
            dec(r);
            pf_chk(r.xpf_code, r.xdst_code, dod_pkg::DEFAULT_WORK_REG_W8, xpf_en, xpf_ptr, xpf_indexed,
                xpf_step, xpf_dst);
            pf_chk(r.ypf_code, r.ydst_code, dod_pkg::DEFAULT_WORK_REG_W10, ypf_en, ypf_ptr, ypf_indexed,
                ypf_step, ypf_dst);
        end
        $display("test prefetch done");
    endtask

    // two requests on consecutive edges, then mul_b_reg must hold while out_valid falls
    task automatic t_b2b();
        dod_req_s r;
        r = idle_req();
        r.sq_code = 2'h1;
        @(posedge clk);
        req = r;
        issue = 1'b1;
        r.sq_code = 2'h3;
        @(posedge clk);
        req = r;
        @(negedge clk);
        chk({3'h0, out_valid, mul_a_reg}, 8'h15);
        @(posedge clk);
        issue = 1'b0;
        @(negedge clk);
        chk({3'h0, out_valid, mul_b_reg}, 8'h17);
        @(negedge clk);
        chk({3'h0, out_valid, mul_b_reg}, 8'h07);
        $display("test back-to-back done");
    endtask

    // reset mid-run swallows a request that arrives with it
    task automatic t_midrst();
        @(posedge clk);
        req = idle_req();
        issue = 1'b1;
        @(negedge clk);
        srst = 1'b1;
        @(posedge clk);
        issue = 1'b0;
        @(negedge clk);
        srst = 1'b0;
        chk_rst();
        $display("test mid reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk_rst();
        t_square();
        t_mul();
        t_regs();
        t_modes();
        t_prefetch();
        t_b2b();
        t_midrst();
        tally_and_finish();
    end

    // watchdog: 4000 cycles, the tests need about 130
    initial
    begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
